/* rtl/rbs_pkg.sv */
// Shared constants and carrier types for the ramp bow, status and pulse-input block
package rbs_pkg;

	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [6:0] ADDR_MODE     = 7'h00;
	localparam logic [6:0] ADDR_XTARGET  = 7'h07;
	localparam logic [6:0] ADDR_BOW      = 7'h08;
	localparam logic [6:0] ADDR_STATUS   = 7'h0b;
	localparam logic [6:0] ADDR_SCALE    = 7'h0d;
	localparam logic [6:0] ADDR_WARN     = 7'h16;

	// ------------------------------------------------------------------
	// Field layouts and widths
	// ------------------------------------------------------------------
	localparam int MODE_W       = 10;
	localparam int MODE_FOLLOW  = 2;
	localparam int BOW_W        = 5;
	localparam logic [4:0] BOW_IDX_MAX = 5'h12;
	localparam int SCALE_W      = 16;
	localparam int SCALE_SIGN   = 15;
	localparam int FRAC_W       = 15;
	localparam int WARN_W       = 20;
	localparam int STAT_W       = 5;
	localparam int ST_POS       = 0;
	localparam int ST_VEL       = 1;
	localparam int ST_STILL     = 2;
	localparam int ST_WARN      = 4;

	// ------------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------------
	localparam logic [MODE_W-1:0]  MODE_RST  = 10'h002;
	localparam logic [BOW_W-1:0]   BOW_RST   = 5'h00;
	localparam logic [SCALE_W-1:0] SCALE_RST = 16'h0000;
	localparam logic [WARN_W-1:0]  WARN_RST  = 20'h00000;
	localparam int JERK_PRESCALE = 1024;
	localparam int JERK_CNT_W    = 10;

	// Present ramp state delivered by the surrounding ramp generator
	typedef struct packed {
		logic signed [31:0] v_actual;
		logic signed [31:0] v_target;
		logic signed [31:0] v_max;
		logic signed [31:0] x_actual;
		logic signed [31:0] loop_err;
		logic               auto_ramp;
		logic               limit_stop;
	} rbs_ramp_t;

endpackage : rbs_pkg

/* rtl/rbs_jerk.sv */
// Bow shaping: steps present acceleration toward its limit at a fixed rate
`timescale 1ns/1ps
module rbs_jerk #(
	parameter int AW = 24
) (
	input  wire logic                         mclk_in,
	input  wire logic                         rst_in,
	input  wire logic [rbs_pkg::BOW_W-1:0]    bow_index_in,
	input  wire logic                         accel_phase_in,
	input  wire logic [AW-1:0]                a_max_in,
	input  wire logic [AW-1:0]                d_max_in,
	output logic      [AW-1:0]                a_actual_out
);

	// ------------------------------------------------------------------
	// Bow value decode
	// ------------------------------------------------------------------
	function automatic logic [AW-1:0] bow_value(input logic [rbs_pkg::BOW_W-1:0] idx);
		logic [rbs_pkg::BOW_W-1:0] k;
		k = (idx > rbs_pkg::BOW_IDX_MAX) ? rbs_pkg::BOW_IDX_MAX : idx;
		bow_value = '0;
		if (k != '0)
			bow_value = AW'(1) << (k - 5'h01);
	endfunction : bow_value

	logic [rbs_pkg::JERK_CNT_W-1:0] cnt_r;
	logic                           tick;
	logic [AW-1:0]                  limit;
	logic [AW-1:0]                  bow;

	assign tick  = (cnt_r == rbs_pkg::JERK_CNT_W'(rbs_pkg::JERK_PRESCALE - 1));
	assign limit = accel_phase_in ? a_max_in : d_max_in;
	assign bow   = bow_value(bow_index_in);

	// ------------------------------------------------------------------
	// Prescaler and acceleration stepping
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 10'h001;
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			a_actual_out <= '0;
		else if (bow_index_in == '0)
			a_actual_out <= limit;
		else if (tick)
		begin
			// Limit lowered below present value snaps down; no overshoot
			if (a_actual_out >= limit || (limit - a_actual_out) <= bow)
				a_actual_out <= limit;
			else
				a_actual_out <= a_actual_out + bow;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_trap_instant: assert property (@(posedge mclk_in) disable iff (rst_in)
		bow_index_in == '0 |=> a_actual_out == $past(limit))
		else $error("trapezoid mode did not follow limit");
	chk_bow_period: assert property (@(posedge mclk_in) disable iff (rst_in)
		(!tick && bow_index_in != '0) |=> $stable(a_actual_out))
		else $error("acceleration changed off the prescaler tick");
	chk_bow_increment: assert property (@(posedge mclk_in) disable iff (rst_in)
		(tick && bow_index_in != '0 && a_actual_out < limit && (limit - a_actual_out) > bow)
		|=> a_actual_out == $past(a_actual_out) + $past(bow))
		else $error("acceleration step is not the bow value");
	cov_bow_reach: cover property (@(posedge mclk_in) disable iff (rst_in)
		bow_index_in != '0 && tick && a_actual_out != limit ##1 a_actual_out == limit);

endmodule : rbs_jerk

/* rtl/rbs_top.sv */
// Ramp bow setting, status flags and scaled step/direction input
//
// Behaviour
// - Bow index zero gives trapezoid ramps with acceleration jumping straight to its limit.
// - Bow index 1 to 18 uses a bow value of two to the power of index minus one.
// - The bow value is added to acceleration every 1024 clocks up to the accel or decel limit.
// - Status bit 0 is set when stopped at the target position or at a position limit.
// - Status bit 1 is set when speed equals target speed, or the ceiling in auto ramps.
// - Status bit 2 is set whenever present speed is zero.
// - Status bit 4 flags encoder deviation above threshold; bit 3 reads zero.
// - Each step pulse moves the target by (increment field plus one) over two to the 15th.
// - Scaling bit 15 chooses whether positive direction counts the target up or down.
// - Step and direction are ignored unless mode bit 2 is set.
// - The warning compares absolute loop error strictly greater than the threshold at 0x16.
`timescale 1ns/1ps
module rbs_top #(
	parameter int AW = 24
) (
	input  wire logic                         mclk_in,
	input  wire logic                         rst_in,
	input  wire logic                         reg_wr_in,
	input  wire logic                         reg_rd_in,
	input  wire logic [6:0]                   reg_addr_in,
	input  wire logic [31:0]                  reg_wdata_in,
	output logic      [31:0]                  reg_rdata_out,
	input  wire logic                         step_in,
	input  wire logic                         dir_in,
	input  wire rbs_pkg::rbs_ramp_t           ramp_in,
	input  wire logic                         accel_phase_in,
	input  wire logic [AW-1:0]                a_max_in,
	input  wire logic [AW-1:0]                d_max_in,
	output logic      [AW-1:0]                a_actual_out,
	output logic signed [31:0]                x_target_out,
	output logic      [rbs_pkg::STAT_W-1:0]   status_out,
	output logic      [rbs_pkg::MODE_W-1:0]   mode_out
);

	function automatic logic [31:0] abs32(input logic signed [31:0] v);
		abs32 = v[31] ? 32'(-v) : 32'(v);
	endfunction : abs32

	logic [rbs_pkg::BOW_W-1:0]   bow_r;
	logic [rbs_pkg::SCALE_W-1:0] scale_r;
	logic [rbs_pkg::WARN_W-1:0]  warn_r;
	logic [rbs_pkg::FRAC_W-1:0]  frac_r;
	logic                        step_d_r;
	logic                        step_edge;
	logic                        step_take;
	logic                        count_up;
	logic [rbs_pkg::SCALE_W-1:0] inc;
	logic [46:0]                 acc_now;
	logic [46:0]                 acc_nxt;
	logic [rbs_pkg::STAT_W-1:0]  status_nxt;
	logic                        wr_xt;

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			mode_out <= rbs_pkg::MODE_RST;
			bow_r    <= rbs_pkg::BOW_RST;
			scale_r  <= rbs_pkg::SCALE_RST;
			warn_r   <= rbs_pkg::WARN_RST;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == rbs_pkg::ADDR_MODE)
				mode_out <= reg_wdata_in[rbs_pkg::MODE_W-1:0];
			else if (reg_addr_in == rbs_pkg::ADDR_BOW)
				bow_r <= reg_wdata_in[rbs_pkg::BOW_W-1:0];
			else if (reg_addr_in == rbs_pkg::ADDR_SCALE)
				scale_r <= reg_wdata_in[rbs_pkg::SCALE_W-1:0];
			else if (reg_addr_in == rbs_pkg::ADDR_WARN)
				warn_r <= reg_wdata_in[rbs_pkg::WARN_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Jerk shaping
	// ------------------------------------------------------------------
	rbs_jerk #(
		.AW (AW)
	) u_jerk (
		.mclk_in        (mclk_in),
		.rst_in         (rst_in),
		.bow_index_in   (bow_r),
		.accel_phase_in (accel_phase_in),
		.a_max_in       (a_max_in),
		.d_max_in       (d_max_in),
		.a_actual_out   (a_actual_out)
	);

	// ------------------------------------------------------------------
	// Step/direction follower
	// ------------------------------------------------------------------
	assign wr_xt     = reg_wr_in && reg_addr_in == rbs_pkg::ADDR_XTARGET;
	assign step_edge = step_in && !step_d_r;
	assign step_take = step_edge && mode_out[rbs_pkg::MODE_FOLLOW];
	assign count_up  = dir_in ^ scale_r[rbs_pkg::SCALE_SIGN];
	assign inc       = {1'b0, scale_r[rbs_pkg::FRAC_W-1:0]} + 16'h0001;
	assign acc_now   = {x_target_out, frac_r};
	assign acc_nxt   = count_up ? acc_now + {31'h0, inc} : acc_now - {31'h0, inc};

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			step_d_r <= 1'b0;
		else
			step_d_r <= step_in;
	end

	// Host write wins over a coincident pulse and restarts the fraction
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			x_target_out <= '0;
			frac_r       <= '0;
		end
		else if (wr_xt)
		begin
			x_target_out <= reg_wdata_in;
			frac_r       <= '0;
		end
		else if (step_take)
		begin
			x_target_out <= acc_nxt[46:rbs_pkg::FRAC_W];
			frac_r       <= acc_nxt[rbs_pkg::FRAC_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------------
	always_comb
	begin
		status_nxt = '0;
		status_nxt[rbs_pkg::ST_STILL] = (ramp_in.v_actual == 32'sh0);
		status_nxt[rbs_pkg::ST_POS] = (ramp_in.v_actual == 32'sh0) &&
			(ramp_in.x_actual == x_target_out || ramp_in.limit_stop);
		status_nxt[rbs_pkg::ST_VEL] = ramp_in.auto_ramp ?
			(ramp_in.v_actual == ramp_in.v_max) :
			(ramp_in.v_actual == ramp_in.v_target);
		status_nxt[rbs_pkg::ST_WARN] =
			abs32(ramp_in.loop_err) > {12'h000, warn_r};
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			status_out <= '0;
		else
			status_out <= status_nxt;
	end

	// ------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			reg_rdata_out <= '0;
		else if (reg_rd_in)
		begin
			if (reg_addr_in == rbs_pkg::ADDR_STATUS)
				reg_rdata_out <= {27'h0, status_out};
			else if (reg_addr_in == rbs_pkg::ADDR_MODE)
				reg_rdata_out <= {22'h0, mode_out};
			else if (reg_addr_in == rbs_pkg::ADDR_XTARGET)
				reg_rdata_out <= x_target_out;
			else
				reg_rdata_out <= '0;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_follow_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
		(!mode_out[rbs_pkg::MODE_FOLLOW] && !wr_xt) |=> $stable(x_target_out))
		else $error("target moved with pulse follow disabled");
	chk_step_scale: assert property (@(posedge mclk_in) disable iff (rst_in)
		(step_take && !wr_xt && count_up) |=>
		{x_target_out, frac_r} == $past(acc_now) + {31'h0, $past(inc)})
		else $error("step did not add scaled increment");
	chk_step_down: assert property (@(posedge mclk_in) disable iff (rst_in)
		(step_take && !wr_xt && !count_up) |=>
		{x_target_out, frac_r} == $past(acc_now) - {31'h0, $past(inc)})
		else $error("step did not count down");
	chk_still_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
		ramp_in.v_actual == 32'sh0 |=> status_out[rbs_pkg::ST_STILL])
		else $error("standstill flag missing");
	chk_pos_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
		ramp_in.v_actual != 32'sh0 |=> !status_out[rbs_pkg::ST_POS])
		else $error("position flag set while moving");
	chk_vel_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
		(!ramp_in.auto_ramp && ramp_in.v_actual == ramp_in.v_target)
		|=> status_out[rbs_pkg::ST_VEL])
		else $error("velocity flag missing");
	chk_warn_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
		!$past(rst_in) |->
		status_out[rbs_pkg::ST_WARN] == $past(abs32(ramp_in.loop_err) > {12'h000, warn_r}))
		else $error("deviation warning wrong");
	chk_reserved_bit: assert property (@(posedge mclk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == rbs_pkg::ADDR_STATUS |=> reg_rdata_out[31:3] ==
		{27'h0, $past(status_out[rbs_pkg::ST_WARN]), 1'b0})
		else $error("status read shows reserved bits");
	cov_step_follow: cover property (@(posedge mclk_in) disable iff (rst_in)
		step_take ##[2:8] step_take);
	cov_warn_raise: cover property (@(posedge mclk_in) disable iff (rst_in)
		!status_out[rbs_pkg::ST_WARN] ##1 status_out[rbs_pkg::ST_WARN]);
	cov_pos_reach: cover property (@(posedge mclk_in) disable iff (rst_in)
		$rose(status_out[rbs_pkg::ST_POS]));

endmodule : rbs_top

/* tb/rbs_host_model.sv */
// Host register master and step/direction pulse source for the block
`timescale 1ns/1ps
module rbs_host_model (
	input  wire logic        mclk_in,
	input  wire logic [31:0] reg_rdata_in,
	output logic             reg_wr_out,
	output logic             reg_rd_out,
	output logic [6:0]       reg_addr_out,
	output logic [31:0]      reg_wdata_out,
	output logic             step_out,
	output logic             dir_out
);
	initial
	begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 7'h00;
		reg_wdata_out = 32'h0;
		step_out = 1'b0;
		dir_out = 1'b0;
	end

	// Released address and data are inverted so stale values never match
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(negedge mclk_in);
		reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(negedge mclk_in);
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [31:0] d);
		@(negedge mclk_in);
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(negedge mclk_in);
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		d = reg_rdata_in;
	endtask : rd

	// Step stays low for two full cycles between back-to-back pulses
	task automatic pulse(input logic d);
		@(negedge mclk_in);
		dir_out = d;
		step_out = 1'b1;
		@(negedge mclk_in);
		step_out = 1'b0;
		@(negedge mclk_in);
	endtask : pulse
endmodule : rbs_host_model

/* tb/rbs_top_tb.sv */
// Self-checking bench for bow shaping, status flags and scaled step input
`timescale 1ns/1ps
module rbs_top_tb;
	logic               mclk_in = 1'b0;
	logic               rst_in = 1'b1;
	logic               wr, rd, step, dir, accel = 1'b1;
	logic [6:0]         addr;
	logic [31:0]        wdata, rdata, d;
	rbs_pkg::rbs_ramp_t ramp = '0;
	logic [23:0]        amax = 24'h0, dmax = 24'h0, a_act;
	logic signed [31:0] xt;
	logic [4:0]         st;
	logic [9:0]         mode;
	logic [46:0]        acc;
	logic [15:0]        scale;
	logic [31:0]        thr;
	int                 n_mismatch = 0, total_checks = 0, i, k, n, e;

	always #10 mclk_in = ~mclk_in;

	rbs_host_model host (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_wr_out(wr),
		.reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata), .step_out(step),
		.dir_out(dir));
	rbs_top #(.AW(24)) uut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.step_in(step), .dir_in(dir), .ramp_in(ramp), .accel_phase_in(accel),
		.a_max_in(amax), .d_max_in(dmax), .a_actual_out(a_act), .x_target_out(xt),
		.status_out(st), .mode_out(mode));

	// ------------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------------
	task automatic finish_test();
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_flags(input logic [4:0] got, input logic [4:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t flags %b expected %b", $time, got, exp);
		end
	endtask : check_flags

	// Bounded wait for the next acceleration step; n counts falling edges
	task automatic wait_step();
		logic [23:0] prev;
		prev = a_act;
		n = 0;
		do
		begin
			@(negedge mclk_in);
			n++;
		end
		while (a_act === prev && n < 1100);
		if (n >= 1100)
		begin
			n_mismatch++;
			finish_test();
		end
	endtask : wait_step

	function automatic logic [4:0] exp_flags(input logic signed [31:0] x);
		logic [31:0] mag;
		mag = ramp.loop_err < 0 ? -ramp.loop_err : ramp.loop_err;
		exp_flags[0] = ramp.v_actual == 0 && (ramp.x_actual == x || ramp.limit_stop);
		exp_flags[1] = ramp.auto_ramp ? ramp.v_actual == ramp.v_max :
			ramp.v_actual == ramp.v_target;
		exp_flags[2] = ramp.v_actual == 0;
		exp_flags[3] = 1'b0;
		exp_flags[4] = mag > thr;
	endfunction : exp_flags

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h7fa5fd65));
		repeat (16) @(negedge mclk_in);
		check_val({22'h0, mode}, 32'h2);
		check_val({8'h0, a_act} | xt | {27'h0, st}, 32'h0);
		rst_in = 1'b0;
		host.rd(7'h7f, d);
		check_val(d, 32'h0);
		host.rd(rbs_pkg::ADDR_BOW, d);
		check_val(d, 32'h0);
		// Bow codes 1..18, each starting from zero acceleration
		for (k = 1; k <= 18; k++)
		begin
			amax = 24'h0;
			host.wr(rbs_pkg::ADDR_BOW, 32'h0);
			repeat (2) @(negedge mclk_in);
			check_val({8'h0, a_act}, 32'h0);
			host.wr(rbs_pkg::ADDR_BOW, k);
			amax = 24'hffffff;
			wait_step();
			check_val({8'h0, a_act}, 32'h1 << (k - 1));
		end
		wait_step();
		check_val(n, 1024);
		check_val({8'h0, a_act}, 32'h20000 * 2);
		// Deceleration toward its own limit, clipped on the last step
		amax = 24'h0;
		host.wr(rbs_pkg::ADDR_BOW, 32'h0);
		repeat (2) @(negedge mclk_in);
		host.wr(rbs_pkg::ADDR_BOW, 32'h5);
		accel = 1'b0;
		dmax = 24'd40;
		for (k = 1; k <= 3; k++)
		begin
			wait_step();
			check_val({8'h0, a_act}, k < 3 ? 16 * k : 40);
		end
		host.wr(rbs_pkg::ADDR_BOW, 32'h0);
		dmax = 24'd7;
		repeat (2) @(negedge mclk_in);
		check_val({8'h0, a_act}, 32'd7);
		// Pulses while following is off leave the target alone
		host.wr(rbs_pkg::ADDR_SCALE, 32'h7fff);
		host.pulse(1'b1);
		check_val(xt, 32'h0);
		host.wr(rbs_pkg::ADDR_MODE, 32'h6);
		host.rd(rbs_pkg::ADDR_MODE, d);
		check_val(d, 32'h6);
		check_val({22'h0, mode}, 32'h6);
		d = $urandom;
		host.wr(rbs_pkg::ADDR_XTARGET, d);
		acc = {d, 15'h0};
		host.rd(rbs_pkg::ADDR_XTARGET, d);
		check_val(d, acc[46:15]);
		for (i = 0; i < 40; i++)
		begin
			if (i % 8 == 0)
			begin
				scale = i == 0 ? 16'h7fff : 16'($urandom);
				host.wr(rbs_pkg::ADDR_SCALE, {16'h0, scale});
			end
			k = $urandom_range(1);
			host.pulse(k[0]);
			if (k[0] ^ scale[15])
				acc = acc + scale[14:0] + 1;
			else
				acc = acc - scale[14:0] - 1;
			check_val(xt, acc[46:15]);
		end
		// Random ramp state, flags on the port and through the register
		thr = $urandom_range(1000, 10);
		host.wr(rbs_pkg::ADDR_WARN, thr);
		for (i = 0; i < 40; i++)
		begin
			@(negedge mclk_in);
			ramp.v_actual = $urandom_range(2);
			ramp.v_target = $urandom_range(2);
			ramp.v_max = $urandom_range(2);
			ramp.x_actual = acc[46:15] + $urandom_range(1);
			ramp.auto_ramp = $urandom_range(1);
			ramp.limit_stop = $urandom_range(1);
			e = int'(thr) + int'($urandom_range(2)) - 1;
			ramp.loop_err = $urandom_range(1) ? -e : e;
			@(negedge mclk_in);
			check_flags(st, exp_flags(acc[46:15]));
			host.rd(rbs_pkg::ADDR_STATUS, d);
			check_val(d, {27'h0, exp_flags(acc[46:15])});
		end
		finish_test();
	end
endmodule : rbs_top_tb
